// ### rtl/ffmtd_pkg.sv
// Package of register map, field layout and constants for the free-fall/motion threshold block.
`default_nettype none
package ffmtd_pkg;
  // ----------------------------------------------------------------------
  // Register byte addresses.
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_COMMON = 8'h17;
  localparam logic [7:0] ADDR_X_HIGH = 8'h73;
  localparam logic [7:0] ADDR_X_LOW = 8'h74;
  localparam logic [7:0] ADDR_Y_HIGH = 8'h75;
  localparam logic [7:0] ADDR_Y_LOW = 8'h76;
  localparam logic [7:0] ADDR_Z_HIGH = 8'h77;
  localparam logic [7:0] ADDR_Z_LOW = 8'h78;
  localparam logic [7:0] ADDR_CONFIG = 8'h80;
  localparam logic [7:0] ADDR_COUNT = 8'h84;
  localparam logic [7:0] ADDR_STATUS = 8'h88;
  localparam logic [7:0] ADDR_MASK = 8'h8C;
  localparam logic [7:0] ADDR_STATE = 8'h90;
  // ----------------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------------
  localparam int THS_W = 13;
  localparam int COMMON_W = 7;
  localparam int HIGH_LSB = 6;
  localparam int CLEAR_MODE_BIT = 7;
  localparam int XYZ_EN_BIT = 7;
  localparam int SHARE_BIT = 7;
  localparam int CFG_FF_MOTION_BIT = 3;
  localparam int STATUS_W = 2;
  localparam int ST_EVENT_BIT = 0;
  localparam int ST_CONFLICT_BIT = 1;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Common threshold weight expressed in output counts per full-scale range.
  localparam logic [12:0] COMMON_SCALE_2G = 13'h0102;
  localparam logic [12:0] COMMON_SCALE_4G = 13'h0081;
  localparam logic [12:0] COMMON_SCALE_8G = 13'h0040;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  typedef enum logic [1:0] {
    FFMTD_IDLE = 2'b00,
    FFMTD_COUNTING = 2'b01,
    FFMTD_EVENT = 2'b11
  } ffmtd_state_e;
endpackage : ffmtd_pkg
`default_nettype wire

// ### rtl/ffmtd_axis_cmp.sv
// Per-axis magnitude comparison against one threshold.
`default_nettype none
module ffmtd_axis_cmp #(
  parameter int DATA_W = 14
) (
  input wire logic [DATA_W-1:0] sample,
  input wire logic [ffmtd_pkg::THS_W-1:0] threshold,
  output logic above,
  output logic below
);
  logic [DATA_W-1:0] magnitude;
  if (DATA_W < ffmtd_pkg::THS_W + 1) begin : g_width_check
    $error("DATA_W too narrow for a 13-bit threshold.");
  end
  always_comb begin
    magnitude = sample[DATA_W-1] ? DATA_W'(-sample) : sample;
    above = magnitude > DATA_W'(threshold);
    below = magnitude < DATA_W'(threshold);
  end
endmodule : ffmtd_axis_cmp
`default_nettype wire

// ### rtl/ffmtd_debounce.sv
// Debounce counter with clear or decrement behaviour on a lapsed condition.
`default_nettype none
module ffmtd_debounce (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic sample_tick,
  input wire logic condition,
  input wire logic clear_mode,
  input wire logic [7:0] count_limit,
  output logic [7:0] count,
  output logic reached
);
  logic [7:0] count_reg;
  logic [7:0] count_next;
  always_comb begin
    count_next = count_reg;
    if (sample_tick) begin
      if (condition) begin
        if (count_reg < count_limit) begin
          count_next = count_reg + 8'h01;
        end else begin
          count_next = count_limit;
        end
      end else if (clear_mode) begin
        count_next = 8'h00;
      end else if (count_reg != 8'h00) begin
        count_next = count_reg - 8'h01;
      end
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= 8'h00;
    end else begin
      count_reg <= count_next;
    end
  end
  assign count = count_reg;
  assign reached = condition && (count_next == count_limit);
endmodule : ffmtd_debounce
`default_nettype wire

// ### rtl/ffmtd_top.sv
// Top of the free-fall/motion threshold and debounce block with its Avalon-MM slave.
`default_nettype none
module ffmtd_top #(
  parameter int DATA_W = 14
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sample_tick,
  input wire logic [DATA_W-1:0] accel_x,
  input wire logic [DATA_W-1:0] accel_y,
  input wire logic [DATA_W-1:0] accel_z,
  input wire logic [1:0] full_scale_range,
  output logic event_flag,
  output logic irq
);
  // ----------------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------------
  logic [7:0] common_reg, common_next;
  logic [7:0] x_high_reg, x_high_next;
  logic [7:0] x_low_reg, x_low_next;
  logic [7:0] y_high_reg, y_high_next;
  logic [7:0] y_low_reg, y_low_next;
  logic [7:0] z_high_reg, z_high_next;
  logic [7:0] z_low_reg, z_low_next;
  logic [7:0] config_reg, config_next;
  logic [7:0] count_limit_reg, count_limit_next;
  logic [ffmtd_pkg::STATUS_W-1:0] status_reg, status_next;
  logic [ffmtd_pkg::STATUS_W-1:0] mask_reg, mask_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wait_reg, wait_next;
  logic event_reg, event_next;
  logic irq_reg, irq_next;
  ffmtd_pkg::ffmtd_state_e state_reg, state_next;
  // ----------------------------------------------------------------------
  // Parameter check.
  // ----------------------------------------------------------------------
  if (DATA_W < ffmtd_pkg::THS_W + 1) begin : g_width_check
    $error("DATA_W too narrow for a 13-bit threshold.");
  end
  // ----------------------------------------------------------------------
  // Threshold selection.
  // ----------------------------------------------------------------------
  function automatic logic [ffmtd_pkg::THS_W-1:0] join_ths(input logic [7:0] high,
                                                          input logic [7:0] low);
    join_ths = {high[6:0], low[5:0]};
  endfunction : join_ths
  logic [ffmtd_pkg::THS_W-1:0] common_scale, common_ths;
  logic [ffmtd_pkg::THS_W-1:0] ths_x, ths_y, ths_z;
  logic xyz_en;
  always_comb begin
    unique case (full_scale_range)
      2'b00: common_scale = ffmtd_pkg::COMMON_SCALE_2G;
      2'b01: common_scale = ffmtd_pkg::COMMON_SCALE_4G;
      default: common_scale = ffmtd_pkg::COMMON_SCALE_8G;
    endcase
    common_ths = scale_ths(common_reg[ffmtd_pkg::COMMON_W-1:0], common_scale);
    xyz_en = x_high_reg[ffmtd_pkg::XYZ_EN_BIT];
    ths_x = xyz_en ? join_ths(x_high_reg, x_low_reg) : common_ths;
    ths_y = xyz_en ? join_ths(y_high_reg, y_low_reg) : common_ths;
    ths_z = xyz_en ? join_ths(z_high_reg, z_low_reg) : common_ths;
  end
  function automatic logic [ffmtd_pkg::THS_W-1:0] scale_ths(input logic [6:0] a,
                                                           input logic [12:0] b);
    logic [19:0] p;
    p = 20'(a) * 20'(b);
    scale_ths = (p > 20'h01FFF) ? 13'h1FFF : p[12:0];
  endfunction : scale_ths
  // ----------------------------------------------------------------------
  // Axis comparison and event condition.
  // ----------------------------------------------------------------------
  logic [2:0] above, below;
  logic [DATA_W-1:0] axis_data [3];
  logic [ffmtd_pkg::THS_W-1:0] axis_ths [3];
  assign axis_data[0] = accel_x;
  assign axis_data[1] = accel_y;
  assign axis_data[2] = accel_z;
  assign axis_ths[0] = ths_x;
  assign axis_ths[1] = ths_y;
  assign axis_ths[2] = ths_z;
  for (genvar i = 0; i < 3; i++) begin : g_axis
    ffmtd_axis_cmp #(.DATA_W(DATA_W)) u_cmp (
      .sample(axis_data[i]),
      .threshold(axis_ths[i]),
      .above(above[i]),
      .below(below[i])
    );
  end
  logic [2:0] axis_en;
  logic motion_mode, condition;
  always_comb begin
    axis_en = config_reg[2:0];
    motion_mode = config_reg[ffmtd_pkg::CFG_FF_MOTION_BIT];
    if (motion_mode) begin
      condition = |(above & axis_en);
    end else begin
      condition = (axis_en != 3'b000) && ((below | ~axis_en) == 3'b111);
    end
  end
  logic [7:0] db_count;
  logic db_reached;
  ffmtd_debounce u_db (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .sample_tick(sample_tick),
    .condition(condition),
    .clear_mode(common_reg[ffmtd_pkg::CLEAR_MODE_BIT]),
    .count_limit(count_limit_reg),
    .count(db_count),
    .reached(db_reached)
  );
  // ----------------------------------------------------------------------
  // Event state machine and interrupt status.
  // ----------------------------------------------------------------------
  logic set_event, set_conflict;
  always_comb begin
    state_next = state_reg;
    set_event = 1'b0;
    if (sample_tick) begin
      unique case (state_reg)
        ffmtd_pkg::FFMTD_IDLE: begin
          if (db_reached) begin
            state_next = ffmtd_pkg::FFMTD_EVENT;
            set_event = 1'b1;
          end else if (condition) begin
            state_next = ffmtd_pkg::FFMTD_COUNTING;
          end
        end
        ffmtd_pkg::FFMTD_COUNTING: begin
          if (db_reached) begin
            state_next = ffmtd_pkg::FFMTD_EVENT;
            set_event = 1'b1;
          end else if (db_count == 8'h00 && !condition) begin
            state_next = ffmtd_pkg::FFMTD_IDLE;
          end
        end
        ffmtd_pkg::FFMTD_EVENT: begin
          if (!db_reached) begin
            state_next = condition ? ffmtd_pkg::FFMTD_COUNTING : ffmtd_pkg::FFMTD_IDLE;
          end
        end
        default: state_next = ffmtd_pkg::FFMTD_IDLE;
      endcase
    end
    event_next = (state_next == ffmtd_pkg::FFMTD_EVENT);
    set_conflict = xyz_en && y_high_reg[ffmtd_pkg::SHARE_BIT];
  end
  // ----------------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, answer on the second edge.
  // ----------------------------------------------------------------------
  logic access, wr_hit, be0;
  logic [ffmtd_pkg::STATUS_W-1:0] w1c;
  always_comb begin
    access = (avs_read || avs_write) && wait_reg;
    wait_next = !access;
    be0 = avs_byteenable[0];
    wr_hit = access && avs_write && be0;
    common_next = common_reg;
    x_high_next = x_high_reg;
    x_low_next = x_low_reg;
    y_high_next = y_high_reg;
    y_low_next = y_low_reg;
    z_high_next = z_high_reg;
    z_low_next = z_low_reg;
    config_next = config_reg;
    count_limit_next = count_limit_reg;
    mask_next = mask_reg;
    w1c = '0;
    rdata_next = rdata_reg;
    if (wr_hit) begin
      unique case (avs_address)
        ffmtd_pkg::ADDR_COMMON: common_next = avs_writedata[7:0];
        ffmtd_pkg::ADDR_X_HIGH: x_high_next = avs_writedata[7:0];
        ffmtd_pkg::ADDR_X_LOW: x_low_next = avs_writedata[7:0];
        ffmtd_pkg::ADDR_Y_HIGH: y_high_next = avs_writedata[7:0];
        ffmtd_pkg::ADDR_Y_LOW: y_low_next = avs_writedata[7:0];
        ffmtd_pkg::ADDR_Z_HIGH: z_high_next = avs_writedata[7:0];
        ffmtd_pkg::ADDR_Z_LOW: z_low_next = avs_writedata[7:0];
        ffmtd_pkg::ADDR_CONFIG: config_next = avs_writedata[7:0];
        ffmtd_pkg::ADDR_COUNT: count_limit_next = avs_writedata[7:0];
        ffmtd_pkg::ADDR_STATUS: w1c = avs_writedata[ffmtd_pkg::STATUS_W-1:0];
        ffmtd_pkg::ADDR_MASK: mask_next = avs_writedata[ffmtd_pkg::STATUS_W-1:0];
        default: w1c = '0;
      endcase
    end
    if (access && avs_read) begin
      unique case (avs_address)
        ffmtd_pkg::ADDR_COMMON: rdata_next = {24'h000000, common_reg};
        ffmtd_pkg::ADDR_X_HIGH: rdata_next = {24'h000000, x_high_reg};
        ffmtd_pkg::ADDR_X_LOW: rdata_next = {24'h000000, x_low_reg};
        ffmtd_pkg::ADDR_Y_HIGH: rdata_next = {24'h000000, y_high_reg};
        ffmtd_pkg::ADDR_Y_LOW: rdata_next = {24'h000000, y_low_reg};
        ffmtd_pkg::ADDR_Z_HIGH: rdata_next = {24'h000000, z_high_reg};
        ffmtd_pkg::ADDR_Z_LOW: rdata_next = {24'h000000, z_low_reg};
        ffmtd_pkg::ADDR_CONFIG: rdata_next = {24'h000000, config_reg};
        ffmtd_pkg::ADDR_COUNT: rdata_next = {24'h000000, count_limit_reg};
        ffmtd_pkg::ADDR_STATUS: rdata_next = {30'h00000000, status_reg};
        ffmtd_pkg::ADDR_MASK: rdata_next = {30'h00000000, mask_reg};
        ffmtd_pkg::ADDR_STATE: rdata_next = {21'h000000, event_reg, state_reg, db_count};
        default: rdata_next = ffmtd_pkg::UNMAPPED_DATA;
      endcase
    end
    status_next = (status_reg & ~w1c);
    status_next[ffmtd_pkg::ST_EVENT_BIT] = status_next[ffmtd_pkg::ST_EVENT_BIT] | set_event;
    status_next[ffmtd_pkg::ST_CONFLICT_BIT] =
      status_next[ffmtd_pkg::ST_CONFLICT_BIT] | set_conflict;
    irq_next = |(status_next & mask_next);
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      common_reg <= ffmtd_pkg::REG_RESET;
      x_high_reg <= ffmtd_pkg::REG_RESET;
      x_low_reg <= ffmtd_pkg::REG_RESET;
      y_high_reg <= ffmtd_pkg::REG_RESET;
      y_low_reg <= ffmtd_pkg::REG_RESET;
      z_high_reg <= ffmtd_pkg::REG_RESET;
      z_low_reg <= ffmtd_pkg::REG_RESET;
      config_reg <= ffmtd_pkg::REG_RESET;
      count_limit_reg <= ffmtd_pkg::REG_RESET;
      status_reg <= '0;
      mask_reg <= '0;
      rdata_reg <= 32'h0000_0000;
      wait_reg <= 1'b1;
      event_reg <= 1'b0;
      irq_reg <= 1'b0;
      state_reg <= ffmtd_pkg::FFMTD_IDLE;
    end else begin
      common_reg <= common_next;
      x_high_reg <= x_high_next;
      x_low_reg <= x_low_next;
      y_high_reg <= y_high_next;
      y_low_reg <= y_low_next;
      z_high_reg <= z_high_next;
      z_low_reg <= z_low_next;
      config_reg <= config_next;
      count_limit_reg <= count_limit_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      wait_reg <= wait_next;
      event_reg <= event_next;
      irq_reg <= irq_next;
      state_reg <= state_next;
    end
  end
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign event_flag = event_reg;
  assign irq = irq_reg;
endmodule : ffmtd_top
`default_nettype wire

// ### verification/ffmtd_properties.sv
// Checker of bus handshake, read data and event flag timing.
`default_nettype none
module ffmtd_checker #(
  parameter int DATA_W = 14
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic sample_tick,
  input wire logic [DATA_W-1:0] accel_x,
  input wire logic [DATA_W-1:0] accel_y,
  input wire logic [DATA_W-1:0] accel_z,
  input wire logic [1:0] full_scale_range,
  input wire logic event_flag,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  a_answer_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held longer than one cycle");
  a_no_idle_answer: assert property (!(avs_read || avs_write) && avs_waitrequest
    |=> avs_waitrequest) else $error("answer without request");
  a_data_holds: assert property ($changed(avs_readdata) |-> $past(avs_read))
    else $error("read data changed without read");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 8'h40
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_flag_on_tick: assert property ($rose(event_flag) |-> $past(sample_tick))
    else $error("event flag rose without sample");
  a_flag_drop_cause: assert property ($fell(event_flag) |-> $past(sample_tick)
    || $past(avs_write) || $past(avs_write, 2)) else $error("event flag fell without cause");
  a_irq_has_cause: assert property ($rose(irq) |-> $past(sample_tick) || $past(avs_write)
    || $past(avs_write, 2)) else $error("irq rose without cause");
  c_event: cover property ($rose(event_flag));
  c_irq: cover property ($rose(irq));
  c_unmapped: cover property (avs_read && !avs_waitrequest && avs_address == 8'h40);
endmodule : ffmtd_checker
bind ffmtd_top ffmtd_checker #(.DATA_W(DATA_W)) chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .sample_tick(sample_tick), .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
  .full_scale_range(full_scale_range), .event_flag(event_flag), .irq(irq));
`default_nettype wire

// ### verification/ffmtd_host_model.sv
// Host model issuing single Avalon-MM register transfers.
`default_nettype none
module ffmtd_host_model (
  input wire logic ref_clk,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    avs_address = 8'h00;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
  end
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
    input logic [3:0] be, output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= ~w;
    avs_write <= w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    @(posedge ref_clk);
    while (avs_waitrequest) @(posedge ref_clk);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    avs_writedata <= ~avs_writedata;
  endtask : xfer
endmodule : ffmtd_host_model
`default_nettype wire

// ### verification/freefall_motion_threshold_debounce_test.sv
// Self-checking bench of the threshold and debounce block.
`default_nettype none
module freefall_motion_threshold_debounce_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, sys_rst, sample_tick, avs_read, avs_write, avs_waitrequest, event_flag, irq;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic [13:0] accel_x, accel_y, accel_z;
  logic [1:0] full_scale_range;
  int errors, comparisons;
  ffmtd_top #(.DATA_W(14)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sample_tick(sample_tick), .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z),
    .full_scale_range(full_scale_range), .event_flag(event_flag), .irq(irq));
  ffmtd_host_model host (.ref_clk(ref_clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(a, 1'h1, d, 4'h1, q);
  endtask : wr
  task automatic tick(input int x, input logic [7:0] c, input logic f);
    @(posedge ref_clk);
    sample_tick <= 1'h1;
    accel_x <= 14'(x);
    @(posedge ref_clk);
    sample_tick <= 1'h0;
    host.xfer(8'h90, 1'h0, 8'h00, 4'hF, q);
    chk("count", {24'h0, q[7:0]}, {24'h0, c});
    chk("event_flag", {30'h0, q[10], event_flag}, {30'h0, f, f});
  endtask : tick
  task automatic irq_is(input logic e);
    repeat (2) @(posedge ref_clk);
    chk("irq", {31'h0, irq}, {31'h0, e});
  endtask : irq_is
  task automatic t_regs();
    logic [7:0] map [5] = '{8'h17, 8'h73, 8'h74, 8'h75, 8'h40};
    foreach (map[i]) begin
      host.xfer(map[i], 1'h0, 8'h00, 4'hF, q);
      chk("reset value", q, 32'h0);
    end
    wr(8'h17, 8'hFF);
    host.xfer(8'h17, 1'h0, 8'h00, 4'hF, q);
    chk("common", q, 32'h0000_00FF);
    host.xfer(8'h84, 1'h1, 8'h05, 4'h0, q);
    host.xfer(8'h84, 1'h0, 8'h00, 4'hF, q);
    chk("byteenable", q, 32'h0);
  endtask : t_regs
  task automatic t_clear();
    wr(8'h80, 8'h0F);
    wr(8'h84, 8'h03);
    wr(8'h73, 8'h80);
    wr(8'h74, 8'h0A);
    wr(8'h17, 8'h80);
    tick(20, 8'h01, 1'h0);
    tick(20, 8'h02, 1'h0);
    tick(5, 8'h00, 1'h0);
    tick(20, 8'h01, 1'h0);
    tick(20, 8'h02, 1'h0);
    tick(20, 8'h03, 1'h1);
    tick(20, 8'h03, 1'h1);
    host.xfer(8'h88, 1'h0, 8'h00, 4'hF, q);
    chk("status", {31'h0, q[0]}, 32'h1);
    irq_is(1'h0);
    wr(8'h8C, 8'h01);
    irq_is(1'h1);
  endtask : t_clear
  task automatic t_decr();
    wr(8'h17, 8'h00);
    tick(5, 8'h02, 1'h0);
    tick(5, 8'h01, 1'h0);
    tick(5, 8'h00, 1'h0);
    tick(5, 8'h00, 1'h0);
    wr(8'h88, 8'h01);
    host.xfer(8'h88, 1'h0, 8'h00, 4'hF, q);
    chk("status", {31'h0, q[0]}, 32'h0);
    irq_is(1'h0);
    wr(8'h73, 8'h00);
    wr(8'h17, 8'h01);
    tick(259, 8'h01, 1'h0);
    tick(259, 8'h02, 1'h0);
    tick(258, 8'h01, 1'h0);
    wr(8'h17, 8'h81);
    tick(259, 8'h02, 1'h0);
    tick(0, 8'h00, 1'h0);
  endtask : t_decr
  task automatic t_thres();
    @(posedge ref_clk);
    full_scale_range <= 2'h1;
    tick(130, 8'h01, 1'h0);
    tick(128, 8'h00, 1'h0);
    wr(8'h17, 8'hFF);
    full_scale_range <= 2'h2;
    tick(8129, 8'h01, 1'h0);
    tick(8128, 8'h00, 1'h0);
    wr(8'h73, 8'h81);
    wr(8'h74, 8'hC0);
    tick(65, 8'h01, 1'h0);
    tick(64, 8'h00, 1'h0);
    tick(-65, 8'h01, 1'h0);
  endtask : t_thres
  task automatic t_ffall();
    wr(8'h80, 8'h03);
    wr(8'h75, 8'h01);
    wr(8'h84, 8'h01);
    accel_y <= 14'h0064;
    tick(10, 8'h00, 1'h0);
    accel_y <= 14'h3FF6;
    tick(10, 8'h01, 1'h1);
    tick(70, 8'h00, 1'h0);
    wr(8'h80, 8'h07);
    tick(10, 8'h00, 1'h0);
    host.xfer(8'h88, 1'h0, 8'h00, 4'hF, q);
    chk("status", {30'h0, q[1:0]}, 32'h1);
    chk("irq", {31'h0, irq}, 32'h1);
  endtask : t_ffall
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    conclude();
  end
  initial begin
    sys_rst = 1'h1;
    sample_tick = 1'h0;
    accel_x = 14'h0000;
    accel_y = 14'h0000;
    accel_z = 14'h0000;
    full_scale_range = 2'h0;
    errors = 0;
    comparisons = 0;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'h0;
    t_regs();
    t_clear();
    t_decr();
    t_thres();
    t_ffall();
    conclude();
  end
endmodule : freefall_motion_threshold_debounce_test
`default_nettype wire
